// ==== osfs_top.v ====
`timescale 1ns/100ps
`include "osfs_regs.vh"
// Fault detection and serial status for an eight-output low-side switch
module osfs_top #(
    parameter FILT_CYC = `OSFS_FILT_CYC
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_clear_n,
    input wire i_cs_n,
    input wire i_sclk,
    input wire i_sdi,
    input wire i_load_supply_ov,
    input wire [7:0] i_overtemp,
    input wire [7:0] i_drain_low,
    input wire [7:0] i_overcurrent,
    output reg o_sdo,
    output reg o_sdo_oe,
    output reg [7:0] o_out_on,
    output reg [7:0] o_ilimit_on,
    output reg [7:0] o_fault
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [2:0] ser_s;
    wire [0:0] clr_s;
    wire [24:0] ana_s;
    // Select travels inverted so the synchroniser's reset zero reads as idle
    wire cs_n_s = ~ser_s[2];
    wire sclk_s = ser_s[1];
    wire sdi_s = ser_s[0];
    wire ov_s = ana_s[24];
    wire [7:0] ot_s = ana_s[23:16];
    wire [7:0] dl_s = ana_s[15:8];
    wire [7:0] oc_s = ana_s[7:0];

    osfs_sync #(.W(3)) u_sync_ser (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async({~i_cs_n, i_sclk, i_sdi}),
        .o_sync(ser_s)
    );

    osfs_sync #(.W(1)) u_sync_clr (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async(~i_clear_n),
        .o_sync(clr_s)
    );

    // Detector levels are analog and free-running
    osfs_sync #(.W(25)) u_sync_ana (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async({i_load_supply_ov, i_overtemp, i_drain_low, i_overcurrent}),
        .o_sync(ana_s)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg cs_n_q;
    reg sclk_q;
    reg [7:0] shift_q;
    reg [7:0] cmd_q;
    reg [7:0] short_q;
    reg [7:0] hot_q;
    reg ov_latch_q;
    reg ov_report_q;
    reg [31:0] filt_cnt_q;
    reg filt_done_q;

    wire cs_fall = cs_n_q & ~cs_n_s;
    wire cs_rise = ~cs_n_q & cs_n_s;
    wire sclk_rise = ~sclk_q & sclk_s;
    wire sclk_fall = sclk_q & ~sclk_s;
    // Clear travels inverted: no false clear edge while the flops fill
    wire cleared = clr_s[0];

    // Commanded on: bit low means on
    wire [7:0] want_on = ~cmd_q;

    // Output stage: thermal per output, over-voltage global, short latched
    wire [7:0] drive_on = want_on & ~ot_s & ~hot_q & ~short_q & {8{~ov_latch_q}};

    // Drain comparator, gated by the filter, serves open load only; short uses the overcurrent input
    wire [7:0] cmp_ok = dl_s & {8{filt_done_q}};
    wire [7:0] open_flt = ~drive_on & ~want_on & cmp_ok;
    wire [7:0] short_flt = drive_on & oc_s & {8{filt_done_q}};

    // ------------------------------------------------------------
    // Status word: drain level, high when off unless open load is flagged
    // ------------------------------------------------------------
    function [7:0] drain_status;
        input [7:0] on;
        input [7:0] openf;
        begin
            drain_status = ~on & ~openf;
        end
    endfunction

    wire [7:0] status_now = ov_report_q ? `OSFS_ALL_OFF :
        drain_status(drive_on, open_flt);

    // ------------------------------------------------------------
    // Edge history
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
        end else begin
            cs_n_q <= cs_n_s;
            sclk_q <= sclk_s;
        end
    end

    // ------------------------------------------------------------
    // Shift register: status loads on select fall, shifts MSB first
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            shift_q <= 8'h00;
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else begin
            o_sdo_oe <= ~cs_n_s;
            if (cleared) begin
                shift_q <= 8'h00;
            end else if (cs_fall) begin
                shift_q <= status_now;
                o_sdo <= status_now[`OSFS_MSB];
            end else if (!cs_n_s && sclk_rise) begin
                shift_q <= {shift_q[6:0], sdi_s};
            end else if (!cs_n_s && sclk_fall) begin
                o_sdo <= shift_q[`OSFS_MSB];
            end
        end
    end

    // ------------------------------------------------------------
    // Command latch, over-voltage and short latches
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            cmd_q <= `OSFS_ALL_OFF;
            short_q <= 8'h00;
            hot_q <= 8'h00;
            ov_latch_q <= 1'b0;
            ov_report_q <= 1'b0;
        end else if (cleared) begin
            cmd_q <= `OSFS_ALL_OFF;
            short_q <= 8'h00;
            hot_q <= ot_s;
        end else begin
            // New write re-arms thermal and short-off outputs; a live over-temperature keeps its latch
            if (cs_rise) begin
                cmd_q <= shift_q;
                short_q <= 8'h00;
                hot_q <= ot_s;
            end else begin
                short_q <= short_q | short_flt;
                hot_q <= hot_q | ot_s;
            end
            // Over-voltage holds until gone and a new write arrives
            if (ov_s) begin
                ov_latch_q <= 1'b1;
                ov_report_q <= 1'b1;
            end else if (cs_rise) begin
                ov_latch_q <= 1'b0;
            end
            // All-ones report lasts through the first frame that starts with over-voltage gone
            if (cs_fall && !ov_s) begin
                ov_report_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Fault filter: restarted by every select rise
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            filt_cnt_q <= 32'h0;
            filt_done_q <= 1'b0;
        end else if (cs_rise) begin
            filt_cnt_q <= 32'h0;
            filt_done_q <= 1'b0;
        end else if (filt_cnt_q < FILT_CYC - 1) begin
            filt_cnt_q <= filt_cnt_q + 32'h1;
        end else begin
            filt_done_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_out_on <= 8'h00;
            o_ilimit_on <= 8'h00;
            o_fault <= 8'h00;
        end else begin
            o_out_on <= drive_on;
            // Limiting follows trip within a few cycles, far under 20 us
            o_ilimit_on <= oc_s & drive_on;
            o_fault <= ot_s | hot_q | open_flt | short_q | {8{ov_latch_q}};
        end
    end
endmodule // osfs_top

// ==== osfs_regs.vh ====
`ifndef OSFS_REGS_VH
`define OSFS_REGS_VH

// ---------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------
`define OSFS_NOUT 8
`define OSFS_ALL_OFF 8'hff
`define OSFS_MSB 7

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define OSFS_CLK_HZ 50000000
`define OSFS_FILT_NS 25000
`define OSFS_FILT_CYC ((`OSFS_FILT_NS * (`OSFS_CLK_HZ / 1000000) + 999) / 1000)

`endif

// ==== osfs_sync.v ====
`timescale 1ns/100ps
// Two-flop synchroniser for a bus of asynchronous levels
module osfs_sync #(
    parameter W = 8
) (
    input wire i_clk,
    input wire i_nrst,
    input wire [W-1:0] i_async,
    output reg [W-1:0] o_sync
);
    reg [W-1:0] meta_q;

    // ------------------------------------------------------------
    // First stage read only by the second
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            meta_q <= {W{1'b0}};
            o_sync <= {W{1'b0}};
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // osfs_sync

// ==== osfs_chk.sv ====
`timescale 1ns/100ps
// ----------------
// Port checker
// ----------------
module osfs_chk (
    input wire i_clk,
    input wire i_nrst,
    input wire i_clear_n,
    input wire i_cs_n,
    input wire i_load_supply_ov,
    input wire [7:0] i_overtemp,
    input wire [7:0] i_drain_low,
    input wire [7:0] i_overcurrent,
    input wire o_sdo_oe,
    input wire [7:0] o_out_on
);
    // Five-cycle margins cover the two-flop synchronisers
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    ov_all_off_a: assert property (i_load_supply_ov[*5] |-> o_out_on == 8'h00)
        else $error("output on during over-voltage");
    ov_hold_a: assert property ((i_load_supply_ov && i_cs_n)[*5] ##1 i_cs_n[*8]
        |-> o_out_on == 8'h00) else $error("output back before rewrite");
    ot_off_a: assert property ($stable(i_overtemp)[*5] |-> (o_out_on & i_overtemp) == 8'h00)
        else $error("hot output still on");
    ot_keep_a: assert property ((i_overtemp[5] && i_cs_n)[*5] ##1 i_cs_n[*8]
        |-> !o_out_on[5]) else $error("output restarted by itself");
    clr_off_a: assert property (!i_clear_n[*5] |-> o_out_on == 8'h00)
        else $error("output on during clear");
    oe_on_a: assert property (!i_cs_n[*5] |-> o_sdo_oe)
        else $error("status out not enabled");
    oe_off_a: assert property (i_cs_n[*5] |-> !o_sdo_oe)
        else $error("status out enabled while deselected");
    out_hold_a: assert property ((i_cs_n && i_clear_n && !i_load_supply_ov && i_overtemp == 0
        && i_drain_low == 0 && i_overcurrent == 0)[*8] |-> $stable(o_out_on))
        else $error("outputs changed without a write");
endmodule // osfs_chk

bind osfs_top osfs_chk chk (.*);

// ==== osfs_host.sv ====
`timescale 1ns/100ps
// ----------------
// Serial host model
// ----------------
module osfs_host (
    input wire i_clk,
    input wire i_sdo,
    output reg o_cs_n = 1'b1,
    output reg o_sclk = 1'b0,
    output reg o_sdi = 1'b0
);
    integer i;
    // One frame, 160 ns sclk; sdi moves with sclk fall, far from the rise
    task xfer(input [7:0] cmd, output [7:0] st);
        o_cs_n <= 1'b0;
        o_sdi <= cmd[7];
        repeat (6) @(posedge i_clk);
        for (i = 7; i >= 0; i = i - 1) begin
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_clk);
            st[i] = i_sdo;
            o_sclk <= 1'b0;
            if (i > 0) begin
                o_sdi <= cmd[i-1];
            end
        end
        o_cs_n <= 1'b1;
        repeat (6) @(posedge i_clk);
    endtask
endmodule // osfs_host

// ==== tb_osfs_top.sv ====
`timescale 1ns/100ps
module tb_osfs_top;
    reg clk, nrst = 0, clr = 1, ov = 0;
    reg [7:0] ot = 0, dl = 0, oc = 0, st;
    wire cs_n, sclk, sdi, sdo;
    wire [7:0] out_on, fault, ilim;
    integer errors = 0;
    integer num_checks = 0;
    osfs_top #(.FILT_CYC(20)) DUT (.i_clk(clk), .i_nrst(nrst), .i_clear_n(clr),
        .i_cs_n(cs_n), .i_sclk(sclk), .i_sdi(sdi), .i_load_supply_ov(ov),
        .i_overtemp(ot), .i_drain_low(dl), .i_overcurrent(oc), .o_sdo(sdo),
        .o_sdo_oe(), .o_out_on(out_on), .o_ilimit_on(ilim), .o_fault(fault));
    osfs_host host (.i_clk(clk), .i_sdo(sdo), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi));
    // ----------------
    // Tasks
    // ----------------
    task chk(input string n, input [7:0] e, input [7:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("mismatch %0s exp %h got %h", n, e, g);
        end
    endtask
    task wt(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task xs(input [7:0] c, input [7:0] e);
        host.xfer(c, st);
        chk("status", e, st);
    endtask
    task co(input [7:0] e);
        chk("outputs", e, out_on);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Clock, 50 MHz
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // Whole run is near 650 cycles, so 5000 means a hang
    initial begin
        #100000;
        errors = errors + 1;
        report_and_stop;
    end
    // Tests; fault waits exceed the shortened filter
    initial begin
        wt(10);
        nrst <= 1'b1;
        wt(5);
        xs(8'h5a, 8'hff);
        xs(8'h5a, 8'h5a);
        co(8'ha5);
        $display("test 1 done");
        dl <= 8'h03;
        oc <= 8'h04;
        wt(50);
        co(8'ha1);
        chk("fault", 8'h06, fault);
        chk("ilimit", 8'h00, ilim);
        xs(8'h5a, 8'h5c);
        dl <= 8'h00;
        oc <= 8'h00;
        ot <= 8'h20;
        wt(50);
        co(8'h85);
        chk("fault", 8'h20, fault);
        ot <= 8'h00;
        wt(20);
        co(8'h85);
        xs(8'h5a, 8'h7a);
        co(8'ha5);
        $display("test 2 done");
        ov <= 1'b1;
        wt(10);
        co(8'h00);
        chk("fault", 8'hff, fault);
        ov <= 1'b0;
        wt(10);
        co(8'h00);
        xs(8'h5a, 8'hff);
        co(8'ha5);
        clr <= 1'b0;
        wt(10);
        co(8'h00);
        clr <= 1'b1;
        wt(30);
        xs(8'h00, 8'hff);
        co(8'hff);
        $display("test 3 done");
        report_and_stop;
    end
endmodule // tb_osfs_top
